// [include/cbpx_pkg.sv]
// cbpx_pkg: constants, enums and structs for the control-transfer and
// processor-management execution block.
// assumes one core clock, AHB-Lite register access, decode stage upstream.
//
// Summary of operation
// - fused compare sets cc, then branches
// - bit test: cc 010 if set, 000 if clear
// - compare-branch format, literal or register operands
// - local call allocates new frame, same stack
// - displacement target relative, extended absolute address
// - system call indexes procedure table for target
// - supervisor entry switches mode; frame advances as for a local call
// - return uses saved caller linkage
// - conditional fault only on cc match
// - mark traces only when breakpoint trace enabled
// - forced mark always produces breakpoint trace
// - trace control holds enables and event flags
// - atomic read-modify-write holds memory lock
// - atomic add sums, atomic modify masks bits
// - process controls readable, writable supervisor only; interrupt control still writes the enable bit in user mode
// - flush writes all sets except current
// - arith controls copied and masked-updated
// - system control is supervisor only
// - cache control enable, disable, lock, invalidate, status
// - halt enters low-power state
// - global interrupt set, clear, load from operand, report
// - cc branch jumps only on cc match
package cbpx_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_OPA    = 8'h04;
  localparam logic [7:0] OFF_OPB    = 8'h08;
  localparam logic [7:0] OFF_OPC    = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_RESULT = 8'h14;
  localparam logic [7:0] OFF_TARGET = 8'h18;
  localparam logic [7:0] OFF_ARITH  = 8'h1C;
  localparam logic [7:0] OFF_PROC   = 8'h20;
  localparam logic [7:0] OFF_TRACE  = 8'h24;
  localparam logic [7:0] OFF_MEM    = 8'h28;
  localparam logic [7:0] OFF_FRAME  = 8'h2C;
  localparam logic [7:0] OFF_SYSTAB = 8'h30;

  // reset values
  localparam logic [31:0] ARITH_RST = 32'h0000_0000;
  localparam logic [31:0] PROC_RST  = 32'h0000_0002; // supervisor after reset
  localparam logic [31:0] TRACE_RST = 32'h0000_0000;

  // field positions
  localparam int PROC_SUP_BIT   = 1;
  localparam int PROC_IE_BIT    = 2;
  localparam int TRACE_BP_EN    = 7;
  localparam int TRACE_BP_EVT   = 23;
  localparam int ARITH_CC_LSB   = 0;
  localparam int CMD_OP_LSB     = 0;
  localparam int CMD_CC_LSB     = 8;
  localparam int CMD_IDX_LSB    = 16;
  localparam int NUM_SETS       = 4;
  localparam int SYSTAB_DEPTH   = 8;
  localparam int FRAME_BYTES    = 64;

  localparam logic [2:0] CC_TRUE  = 3'h2;
  localparam logic [2:0] CC_FALSE = 3'h0;

  typedef enum logic [4:0] {
    CBPX_OP_NOP    = 5'h00, CBPX_OP_CMPIB  = 5'h01, CBPX_OP_CMPOB = 5'h02,
    CBPX_OP_BBS    = 5'h03, CBPX_OP_BBC    = 5'h04, CBPX_OP_BCC   = 5'h05,
    CBPX_OP_CALL   = 5'h06, CBPX_OP_CALLX  = 5'h07, CBPX_OP_CALLS = 5'h08,
    CBPX_OP_RET    = 5'h09, CBPX_OP_FAULT  = 5'h0A, CBPX_OP_MARK  = 5'h0B,
    CBPX_OP_FMARK  = 5'h0C, CBPX_OP_MODTC  = 5'h0D, CBPX_OP_ATADD = 5'h0E,
    CBPX_OP_ATMOD  = 5'h0F, CBPX_OP_MODPC  = 5'h10, CBPX_OP_FLUSH = 5'h11,
    CBPX_OP_MODAC  = 5'h12, CBPX_OP_SYSCTL = 5'h13, CBPX_OP_CACHE = 5'h14,
    CBPX_OP_HALT   = 5'h15, CBPX_OP_INTCTL = 5'h16
  } cbpx_op_t;

  // one-hot sequencer states
  typedef enum logic [3:0] {
    CBPX_IDLE  = 4'h1,
    CBPX_READ  = 4'h2,
    CBPX_WRITE = 4'h4,
    CBPX_FLUSH = 4'h8
  } cbpx_state_t;

  // memory request carried to the core memory port
  typedef struct packed {
    logic        req;
    logic        we;
    logic        lock;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cbpx_mem_req_t;

  // outcome flags of the last operation
  typedef struct packed {
    logic taken;
    logic fault;
    logic prot_fault;
    logic trace_evt;
    logic halted;
    logic busy;
  } cbpx_flags_t;

endpackage

// [hw/cbpx_exec.sv]
// cbpx_exec: executes compare-branch, call/return, faults, trace marks,
// atomics and privileged management ops issued through registers.
// assumes a single AHB-Lite master and a memory port that answers with mem_ack.
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module cbpx_exec (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // memory port
  output cbpx_pkg::cbpx_mem_req_t     mem_req,
  input  wire logic                   mem_ack,
  input  wire logic [31:0]            mem_rdata,
  // core side effects
  output logic                        halt_out,
  output logic                        int_enable,
  output logic                        sw_int,
  output logic                        core_reinit,
  output logic      [3:0]             cache_ctl
);

  cbpx_pkg::cbpx_state_t state_reg;
  cbpx_pkg::cbpx_flags_t flags_reg;
  logic [31:0] cmd_reg, opa_reg, opb_reg, opc_reg;
  logic [31:0] result_reg, target_reg, arith_reg, proc_reg, trace_reg;
  logic [31:0] mem_addr_reg, frame_reg;
  logic [31:0] systab_reg [cbpx_pkg::SYSTAB_DEPTH];
  logic [31:0] saved_rip_reg, saved_frame_reg;
  logic        saved_sup_reg;
  logic [1:0]  flush_cnt_reg;
  logic        go_reg;

  // bus address phase capture
  logic        ph_wr_reg, ph_rd_reg;
  logic [7:0]  ph_addr_reg;
  logic        acc;
  assign acc       = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;  // every access finishes in one data phase
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ph_wr_reg   <= 1'b0;
      ph_rd_reg   <= 1'b0;
      ph_addr_reg <= 8'h00;
    end else begin
      ph_wr_reg   <= acc && hwrite;
      ph_rd_reg   <= acc && !hwrite;
      ph_addr_reg <= haddr[7:0];
    end
  end

  // decoded command fields
  cbpx_pkg::cbpx_op_t op;
  logic [2:0] cc_mask, cc_now, cmp_cc;
  logic [2:0] idx;
  logic       sup, bit_val, cc_hit, entry_sup;
  logic [31:0] entry;
  assign op      = cbpx_pkg::cbpx_op_t'(cmd_reg[cbpx_pkg::CMD_OP_LSB +: 5]);
  assign cc_mask = cmd_reg[cbpx_pkg::CMD_CC_LSB +: 3];
  assign idx     = cmd_reg[cbpx_pkg::CMD_IDX_LSB +: 3];
  assign cc_now  = arith_reg[cbpx_pkg::ARITH_CC_LSB +: 3];
  assign sup     = proc_reg[cbpx_pkg::PROC_SUP_BIT];
  assign bit_val = opb_reg[opa_reg[4:0]];
  assign entry   = systab_reg[idx];
  assign entry_sup = entry[1];

  // compare result coded as less 100, equal 010, greater 001
  always_comb begin
    cmp_cc = 3'h0;
    if (opa_reg == opb_reg) begin
      cmp_cc = 3'h2;
    end else if (op == cbpx_pkg::CBPX_OP_CMPIB) begin
      cmp_cc = ($signed(opa_reg) < $signed(opb_reg)) ? 3'h4 : 3'h1;
    end else begin
      cmp_cc = (opa_reg < opb_reg) ? 3'h4 : 3'h1;
    end
  end

  // a match is any overlap of cc with the instruction mask; mask 000 means cc 000
  function automatic logic cc_match(input logic [2:0] cc, input logic [2:0] m);
    cc_match = (m == 3'h0) ? (cc == 3'h0) : |(cc & m);
  endfunction
  assign cc_hit = cc_match(cc_now, cc_mask);

  // register writes and the command engine, one cycle per simple op
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= 32'h0000_0000; opa_reg <= 32'h0000_0000;
      opb_reg <= 32'h0000_0000; opc_reg <= 32'h0000_0000;
      mem_addr_reg <= 32'h0000_0000; frame_reg <= 32'h0000_0000;
      go_reg  <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (ph_wr_reg) begin
        case (ph_addr_reg)
          cbpx_pkg::OFF_CMD: begin
            cmd_reg <= hwdata;
            go_reg  <= state_reg == cbpx_pkg::CBPX_IDLE; // ignored while busy
          end
          cbpx_pkg::OFF_OPA:   opa_reg      <= hwdata;
          cbpx_pkg::OFF_OPB:   opb_reg      <= hwdata;
          cbpx_pkg::OFF_OPC:   opc_reg      <= hwdata;
          cbpx_pkg::OFF_MEM:   mem_addr_reg <= hwdata;
          cbpx_pkg::OFF_FRAME: frame_reg    <= hwdata;
          default: ;
        endcase
      end
      if (go_reg) begin
        case (op)
          cbpx_pkg::CBPX_OP_CALL, cbpx_pkg::CBPX_OP_CALLX,
          cbpx_pkg::CBPX_OP_CALLS: frame_reg <= frame_reg + 32'(cbpx_pkg::FRAME_BYTES);
          cbpx_pkg::CBPX_OP_RET:   frame_reg <= saved_frame_reg;
          default: ;
        endcase
      end
    end
  end

  // system procedure table, loaded by software
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < cbpx_pkg::SYSTAB_DEPTH; i++) systab_reg[i] <= 32'h0000_0000;
    end else if (ph_wr_reg && ph_addr_reg == cbpx_pkg::OFF_SYSTAB) begin
      systab_reg[hwdata[2:0]] <= {opc_reg[31:2], 2'h0} | {30'h0, hwdata[3], 1'b0};
    end
  end

  // architectural state: arith, process and trace controls, flow results
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arith_reg <= cbpx_pkg::ARITH_RST; proc_reg <= cbpx_pkg::PROC_RST;
      trace_reg <= cbpx_pkg::TRACE_RST; flags_reg <= '0;
      result_reg <= 32'h0000_0000; target_reg <= 32'h0000_0000;
      saved_rip_reg <= 32'h0000_0000; saved_frame_reg <= 32'h0000_0000;
      saved_sup_reg <= 1'b0; sw_int <= 1'b0; core_reinit <= 1'b0;
      cache_ctl <= 4'h0;
    end else begin
      sw_int      <= 1'b0;
      core_reinit <= 1'b0;
      if (go_reg) begin
        flags_reg.taken      <= 1'b0;
        flags_reg.fault      <= 1'b0;
        flags_reg.prot_fault <= 1'b0;
        flags_reg.trace_evt  <= 1'b0;
        case (op)
          cbpx_pkg::CBPX_OP_CMPIB, cbpx_pkg::CBPX_OP_CMPOB: begin
            arith_reg[2:0]  <= cmp_cc;
            flags_reg.taken <= cc_match(cmp_cc, cc_mask);
            target_reg      <= opc_reg + 32'(signed'(cmd_reg[31:19]));
          end
          cbpx_pkg::CBPX_OP_BBS, cbpx_pkg::CBPX_OP_BBC: begin
            arith_reg[2:0]  <= bit_val ? cbpx_pkg::CC_TRUE : cbpx_pkg::CC_FALSE;
            flags_reg.taken <= (op == cbpx_pkg::CBPX_OP_BBS) == bit_val;
            target_reg      <= opc_reg + 32'(signed'(cmd_reg[31:19]));
          end
          cbpx_pkg::CBPX_OP_BCC: begin
            flags_reg.taken <= cc_hit;
            target_reg      <= opc_reg + opb_reg;
          end
          cbpx_pkg::CBPX_OP_CALL, cbpx_pkg::CBPX_OP_CALLX: begin
            saved_rip_reg   <= opc_reg + 32'h0000_0004;
            saved_frame_reg <= frame_reg;
            saved_sup_reg   <= sup;
            flags_reg.taken <= 1'b1;
            target_reg <= (op == cbpx_pkg::CBPX_OP_CALL) ? opc_reg + opb_reg : opa_reg;
          end
          cbpx_pkg::CBPX_OP_CALLS: begin
            saved_rip_reg   <= opc_reg + 32'h0000_0004;
            saved_frame_reg <= frame_reg;
            saved_sup_reg   <= sup;
            flags_reg.taken <= 1'b1;
            target_reg      <= {entry[31:2], 2'h0};
            if (entry_sup) proc_reg[cbpx_pkg::PROC_SUP_BIT] <= 1'b1;
          end
          cbpx_pkg::CBPX_OP_RET: begin
            target_reg      <= saved_rip_reg;
            flags_reg.taken <= 1'b1;
            proc_reg[cbpx_pkg::PROC_SUP_BIT] <= saved_sup_reg;
          end
          cbpx_pkg::CBPX_OP_FAULT: flags_reg.fault <= cc_hit;
          cbpx_pkg::CBPX_OP_MARK: begin
            if (trace_reg[cbpx_pkg::TRACE_BP_EN]) begin
              flags_reg.trace_evt <= 1'b1;
              trace_reg[cbpx_pkg::TRACE_BP_EVT] <= 1'b1;
            end
          end
          cbpx_pkg::CBPX_OP_FMARK: begin
            flags_reg.trace_evt <= 1'b1;
            trace_reg[cbpx_pkg::TRACE_BP_EVT] <= 1'b1;
          end
          cbpx_pkg::CBPX_OP_MODTC: begin
            result_reg <= trace_reg;
            trace_reg  <= (trace_reg & ~opa_reg) | (opb_reg & opa_reg);
          end
          cbpx_pkg::CBPX_OP_MODPC: begin
            result_reg <= proc_reg;
            if (opa_reg != 32'h0000_0000) begin
              if (sup) proc_reg <= (proc_reg & ~opa_reg) | (opb_reg & opa_reg);
              else flags_reg.prot_fault <= 1'b1;
            end
          end
          cbpx_pkg::CBPX_OP_MODAC: begin
            result_reg <= arith_reg;
            arith_reg  <= (arith_reg & ~opa_reg) | (opb_reg & opa_reg);
          end
          cbpx_pkg::CBPX_OP_SYSCTL: begin
            if (!sup) flags_reg.prot_fault <= 1'b1;
            else case (opa_reg[1:0])
              2'h0: sw_int      <= 1'b1;
              2'h1: core_reinit <= 1'b1;
              2'h2: trace_reg   <= opb_reg;
              default: cache_ctl[0] <= opb_reg[0];
            endcase
          end
          cbpx_pkg::CBPX_OP_CACHE: begin
            case (opa_reg[2:0])
              3'h0: cache_ctl[1:0] <= 2'h1;                               // enable
              3'h1: cache_ctl[1:0] <= 2'h0;                               // disable
              3'h2: cache_ctl[2]   <= 1'b1;                               // lock
              3'h3: cache_ctl[3]   <= 1'b1;                               // invalidate
              default: result_reg  <= {28'h0, cache_ctl};                 // status
            endcase
          end
          cbpx_pkg::CBPX_OP_INTCTL: begin
            result_reg <= {31'h0, proc_reg[cbpx_pkg::PROC_IE_BIT]};
            case (opa_reg[1:0])
              2'h0: proc_reg[cbpx_pkg::PROC_IE_BIT] <= 1'b1;
              2'h1: proc_reg[cbpx_pkg::PROC_IE_BIT] <= 1'b0;
              2'h2: proc_reg[cbpx_pkg::PROC_IE_BIT] <= opb_reg[0];
              default: ;
            endcase
          end
          default: ;
        endcase
      end else if (state_reg == cbpx_pkg::CBPX_READ && mem_ack) begin
        result_reg <= mem_rdata;  // old memory value returned to software
      end
      // software clears sticky trace event by writing one
      if (ph_wr_reg && ph_addr_reg == cbpx_pkg::OFF_TRACE && !go_reg) begin
        trace_reg <= trace_reg & ~(hwdata & (32'h1 << cbpx_pkg::TRACE_BP_EVT));
      end
      flags_reg.busy   <= state_reg != cbpx_pkg::CBPX_IDLE;
      flags_reg.halted <= halt_out;
    end
  end

  // halt latch: released only by a write of one to the status register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) halt_out <= 1'b0;
    else if (go_reg && op == cbpx_pkg::CBPX_OP_HALT) halt_out <= 1'b1;
    else if (ph_wr_reg && ph_addr_reg == cbpx_pkg::OFF_STATUS && hwdata[0]) halt_out <= 1'b0;
  end
  assign int_enable = proc_reg[cbpx_pkg::PROC_IE_BIT];

  // memory sequencer: atomics and register flush; lock spans read and write
  logic [31:0] mod_val;
  assign mod_val = (op == cbpx_pkg::CBPX_OP_ATADD) ? result_reg + opb_reg
                 : (result_reg & ~opa_reg) | (opb_reg & opa_reg);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg     <= cbpx_pkg::CBPX_IDLE;
      flush_cnt_reg <= 2'h0;
      mem_req       <= '0;
    end else begin
      case (state_reg)
        cbpx_pkg::CBPX_IDLE: begin
          if (go_reg && (op == cbpx_pkg::CBPX_OP_ATADD || op == cbpx_pkg::CBPX_OP_ATMOD)) begin
            state_reg <= cbpx_pkg::CBPX_READ;
            mem_req   <= '{req: 1'b1, we: 1'b0, lock: 1'b1,
                           addr: mem_addr_reg, wdata: 32'h0000_0000};
          end else if (go_reg && op == cbpx_pkg::CBPX_OP_FLUSH) begin
            state_reg     <= cbpx_pkg::CBPX_FLUSH;
            flush_cnt_reg <= 2'h1;  // set 0 is the active one and stays put
            mem_req <= '{req: 1'b1, we: 1'b1, lock: 1'b0,
                         addr: frame_reg - 32'(cbpx_pkg::FRAME_BYTES), wdata: opb_reg};
          end
        end
        cbpx_pkg::CBPX_READ: if (mem_ack) begin
          state_reg <= cbpx_pkg::CBPX_WRITE;
          mem_req.req <= 1'b0;
        end
        cbpx_pkg::CBPX_WRITE: begin
          if (!mem_req.req) begin
            mem_req.req <= 1'b1; mem_req.we <= 1'b1; mem_req.wdata <= mod_val;
          end else if (mem_ack) begin
            state_reg <= cbpx_pkg::CBPX_IDLE;
            mem_req   <= '0;
          end
        end
        cbpx_pkg::CBPX_FLUSH: if (mem_ack) begin
          if (flush_cnt_reg == 2'(cbpx_pkg::NUM_SETS - 1)) begin
            state_reg <= cbpx_pkg::CBPX_IDLE;
            mem_req   <= '0;
          end else begin
            flush_cnt_reg <= flush_cnt_reg + 2'h1;
            mem_req.addr  <= mem_req.addr - 32'(cbpx_pkg::FRAME_BYTES);
          end
        end
        default: state_reg <= cbpx_pkg::CBPX_IDLE;
      endcase
    end
  end

  // read mux: process and trace controls readable at any privilege
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hrdata <= 32'h0000_0000;
    else if (acc && !hwrite) begin
      case (haddr[7:0])
        cbpx_pkg::OFF_CMD:    hrdata <= cmd_reg;
        cbpx_pkg::OFF_OPA:    hrdata <= opa_reg;
        cbpx_pkg::OFF_OPB:    hrdata <= opb_reg;
        cbpx_pkg::OFF_OPC:    hrdata <= opc_reg;
        cbpx_pkg::OFF_STATUS: hrdata <= {26'h0, flags_reg};
        cbpx_pkg::OFF_RESULT: hrdata <= result_reg;
        cbpx_pkg::OFF_TARGET: hrdata <= target_reg;
        cbpx_pkg::OFF_ARITH:  hrdata <= arith_reg;
        cbpx_pkg::OFF_PROC:   hrdata <= proc_reg;
        cbpx_pkg::OFF_TRACE:  hrdata <= trace_reg;
        cbpx_pkg::OFF_MEM:    hrdata <= mem_addr_reg;
        cbpx_pkg::OFF_FRAME:  hrdata <= frame_reg;
        default:              hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// [sim/cbpx_exec_props.sv]
// cbpx_exec_props: port-level assertions for the execution block.
// assumes it is bound to cbpx_exec and sees only that module's ports.
`timescale 1ns/1ps
module cbpx_exec_props (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     resetn,
  // bus answer
  input wire logic                     hreadyout,
  input wire logic                     hresp,
  // memory port and side effects
  input cbpx_pkg::cbpx_mem_req_t       mem_req,
  input wire logic                     mem_ack,
  input wire logic                     sw_int,
  input wire logic                     core_reinit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // locked read accepted by memory: the write half must follow on the same word
  wire rd_done = mem_req.req & mem_req.lock & ~mem_req.we & mem_ack;

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  chk_req_held: assert property (mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req.addr))
    else $error("memory request dropped before ack");
  chk_lock_span: assert property (rd_done |=> mem_req.lock ##1 mem_req.req && mem_req.we && mem_req.lock)
    else $error("atomic write half missing or unlocked");
  chk_same_word: assert property (rd_done |=> ##1 mem_req.addr == $past(mem_req.addr, 2))
    else $error("atomic write to another word");
  chk_write_locked: assert property (mem_req.req && mem_req.we && mem_req.lock |-> $past(mem_req.lock))
    else $error("locked write without preceding locked read");
  chk_unlocked_write: assert property (mem_req.req && !mem_req.lock |-> mem_req.we)
    else $error("unlocked memory read seen");
  chk_swint_pulse: assert property (sw_int |=> !sw_int)
    else $error("software interrupt longer than one cycle");
  chk_reinit_pulse: assert property (core_reinit |=> !core_reinit)
    else $error("reinit longer than one cycle");

  // main scenarios reached
  cov_atomic: cover property (rd_done);
  cov_flush: cover property (mem_req.req && !mem_req.lock);
  cov_swint: cover property (sw_int);
endmodule

bind cbpx_exec cbpx_exec_props chk_u (
  .clk(clk), .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp),
  .mem_req(mem_req), .mem_ack(mem_ack), .sw_int(sw_int), .core_reinit(core_reinit)
);

// [sim/cbpx_exec_test.sv]
// cbpx_exec_test: self-checking bench, expectations from a behavioural model.
// assumes a zero-wait bus slave and a memory port that waits for mem_ack.
`timescale 1ns/1ps
module cbpx_exec_test;
  // bus master, memory and side-effect signals
  logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, mem_ack = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, mem_rdata = 32'h0, hrdata;
  logic        hready, hresp, halt_out, int_en, sw_int, reinit;
  logic [3:0]  cache_ctl;
  cbpx_pkg::cbpx_mem_req_t mreq;
  logic [31:0] mem [logic [31:0]];
  logic [63:0] wq [$];
  logic [31:0] rv, st, a, b, x;
  logic [12:0] d;
  logic [2:0]  cc, m;
  logic        tk, ie;
  int          o, n_mismatch = 0, cmp_count = 0, n_sw = 0, n_ri = 0;

  always #10 clk = ~clk;

  cbpx_exec dut_u (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .mem_req(mreq), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .halt_out(halt_out), .int_enable(int_en), .sw_int(sw_int),
    .core_reinit(reinit), .cache_ctl(cache_ctl));

  // memory answers after a random wait; data scrambles when not answering
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    n_sw += (sw_int === 1'b1);
    n_ri += (reinit === 1'b1);
    if (mreq.req === 1'b1 && !mem_ack && $urandom_range(1, 0)) begin
      mem_ack <= 1'b1;
      mem_rdata <= mreq.we ? ~mem_rdata : mem[mreq.addr];
      if (mreq.we) wq.push_back({mreq.addr, mreq.wdata});
      if (mreq.we) mem[mreq.addr] = mreq.wdata;
    end
  end

  task automatic complete_run;
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [63:0] s, logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask

  // one single transfer; a hang is cut short as a mismatch
  task automatic xfer(bit wr, logic [7:0] ad, logic [31:0] dt);
    int k;
    k = 0;
    @(posedge clk);
    haddr <= 32'(ad);
    hwrite <= wr;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1 && ++k < 50);
    htrans <= 2'h0;
    hwdata <= dt;
    do @(posedge clk); while (hready !== 1'b1 && ++k < 50);
    rv = hrdata;
    if (k >= 50) begin
      chk("bus_wait", 0, 1);
      complete_run();
    end
  endtask

  task automatic rdc(logic [7:0] ad, logic [31:0] mk, logic [31:0] e, string nm);
    xfer(0, ad, 32'h0);
    chk(nm, rv & mk, e);
  endtask

  // operands first, then the command; poll busy with a bound
  task automatic op(logic [31:0] c, logic [31:0] pa = 0, pb = 0, pc = 0);
    int k;
    k = 0;
    xfer(1, cbpx_pkg::OFF_OPA, pa);
    xfer(1, cbpx_pkg::OFF_OPB, pb);
    xfer(1, cbpx_pkg::OFF_OPC, pc);
    xfer(1, cbpx_pkg::OFF_CMD, c);
    xfer(0, cbpx_pkg::OFF_STATUS, 32'h0);  // busy flag lags the sequencer
    do xfer(0, cbpx_pkg::OFF_STATUS, 32'h0); while (rv[0] !== 1'b0 && ++k < 200);
    st = rv;
    if (k >= 200) begin
      chk("busy_wait", 0, 1);
      complete_run();
    end
  endtask

  function automatic logic [31:0] cmd(cbpx_pkg::cbpx_op_t op_c, logic [2:0] c = 0,
                                      logic [2:0] ix = 0, logic [12:0] dp = 0);
    return {dp, ix, 5'h0, c, 3'h0, op_c};
  endfunction

  function automatic bit hit(logic [2:0] c, logic [2:0] mk);
    return (c & mk) != 0 || (mk == 0 && c == 0);
  endfunction

  initial begin
    void'($urandom(32'hC619));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rdc(cbpx_pkg::OFF_PROC, '1, cbpx_pkg::PROC_RST, "proc_rst");
    rdc(cbpx_pkg::OFF_TRACE, '1, cbpx_pkg::TRACE_RST, "trace_rst");
    rdc(cbpx_pkg::OFF_ARITH, '1, cbpx_pkg::ARITH_RST, "arith_rst");
    xfer(1, 8'h3C, 32'hFFFFFFFF);
    rdc(8'h3C, '1, 32'h0, "unmapped");
    // fused compares and bit tests over every mask, then branch and fault on that cc
    for (int i = 0; i < 32; i++) begin
      o = i / 8;
      m = 3'(i);
      a = o > 1 ? $urandom_range(31, 0) : $urandom;
      b = (i % 3 == 0 && o < 2) ? a : $urandom;
      x = $urandom;
      d = 13'($urandom);
      cc = (o == 0 ? $signed(a) < $signed(b) : a < b) ? 3'h4 : (a == b ? 3'h2 : 3'h1);
      if (o > 1) cc = b[a[4:0]] ? 3'h2 : 3'h0;
      tk = o < 2 ? hit(cc, m) : cc[1] ^ (o == 3);
      op(cmd(cbpx_pkg::cbpx_op_t'(5'(o + 1)), m, 3'h0, d), a, b, x);
      chk("taken", st[5], tk);
      rdc(cbpx_pkg::OFF_ARITH, 32'h7, 32'(cc), "cc");
      if (tk) rdc(cbpx_pkg::OFF_TARGET, '1, x + 32'($signed(d)), "compare_branch_format_tgt");
      m = 3'($urandom);
      op(cmd(cbpx_pkg::CBPX_OP_BCC, m), 32'h0, b, x);
      chk("bcc", st[5], hit(cc, m));
      if (hit(cc, m)) rdc(cbpx_pkg::OFF_TARGET, '1, x + b, "bcc_tgt");
      op(cmd(cbpx_pkg::CBPX_OP_FAULT, m));
      chk("fault", st[4], hit(cc, m));
    end
    // table: index 1 local type, index 2 supervisor type
    xfer(1, cbpx_pkg::OFF_OPC, 32'h4447);
    xfer(1, cbpx_pkg::OFF_SYSTAB, 32'h1);
    xfer(1, cbpx_pkg::OFF_OPC, 32'h8886);
    xfer(1, cbpx_pkg::OFF_SYSTAB, 32'hA);
    // drop to user mode; privileged changes are then refused
    op(cmd(cbpx_pkg::CBPX_OP_MODPC), 32'h2, 32'h0);
    rdc(cbpx_pkg::OFF_PROC, 32'h2, 32'h0, "user");
    op(cmd(cbpx_pkg::CBPX_OP_MODPC), 32'h2, 32'h2);
    chk("modpc_prot", st[3], 1);
    rdc(cbpx_pkg::OFF_PROC, 32'h2, 32'h0, "still_user");
    op(cmd(cbpx_pkg::CBPX_OP_SYSCTL));
    chk("sysctl_prot", st[3], 1);
    // local then supervisor system call, each unwound by a return
    op(cmd(cbpx_pkg::CBPX_OP_CALLS, 3'h0, 3'h1), 0, 0, 32'h100);
    rdc(cbpx_pkg::OFF_TARGET, '1, 32'h4444, "calls_l");
    rdc(cbpx_pkg::OFF_PROC, 32'h2, 32'h0, "mode_l");
    op(cmd(cbpx_pkg::CBPX_OP_RET));
    rdc(cbpx_pkg::OFF_TARGET, '1, 32'h104, "ret_l");
    op(cmd(cbpx_pkg::CBPX_OP_CALLS, 3'h0, 3'h2), 0, 0, 32'h200);
    rdc(cbpx_pkg::OFF_TARGET, '1, 32'h8884, "calls_s");
    rdc(cbpx_pkg::OFF_PROC, 32'h2, 32'h2, "mode_s");
    op(cmd(cbpx_pkg::CBPX_OP_RET));
    rdc(cbpx_pkg::OFF_TARGET, '1, 32'h204, "ret_s");
    rdc(cbpx_pkg::OFF_PROC, 32'h2, 32'h0, "ret_mode");
    // local calls from a known frame, then flush of the older sets
    xfer(1, cbpx_pkg::OFF_FRAME, 32'h2000);
    op(cmd(cbpx_pkg::CBPX_OP_CALL), 0, 32'h40, 32'h300);
    rdc(cbpx_pkg::OFF_TARGET, '1, 32'h340, "call");
    op(cmd(cbpx_pkg::CBPX_OP_CALLX), 32'h12345678, 0, 32'h400);
    rdc(cbpx_pkg::OFF_TARGET, '1, 32'h12345678, "callx");
    op(cmd(cbpx_pkg::CBPX_OP_RET));
    rdc(cbpx_pkg::OFF_TARGET, '1, 32'h404, "ret_x");
    wq.delete();
    b = $urandom;
    op(cmd(cbpx_pkg::CBPX_OP_FLUSH), 0, b);
    chk("flush_n", wq.size(), 3);
    for (int k = 0; k < 3; k++) chk("flush", wq[k], {32'h2040 - 64 * (k + 1), b});
    // back to supervisor; system control, cache and interrupt enable
    op(cmd(cbpx_pkg::CBPX_OP_CALLS, 3'h0, 3'h2), 0, 0, 32'h500);
    for (int s = 0; s < 4; s++) op(cmd(cbpx_pkg::CBPX_OP_SYSCTL), s, 32'h1);
    chk("sysctl_fx", {n_sw[1:0], n_ri[1:0], cache_ctl[0]}, 5'b01011);
    for (int s = 0; s < 5; s++) op(cmd(cbpx_pkg::CBPX_OP_CACHE), s);
    chk("cache", cache_ctl[3:2], 2'b11);
    ie = 1'b0;
    for (int s = 0; s < 4; s++) begin
      b = $urandom;
      op(cmd(cbpx_pkg::CBPX_OP_INTCTL), s, b);
      rdc(cbpx_pkg::OFF_RESULT, 32'h1, 32'(ie), "ie_old");
      ie = s == 0 ? 1'b1 : s == 1 ? 1'b0 : s == 2 ? b[0] : ie;
      chk("ie", int_en, ie);
    end
    op(cmd(cbpx_pkg::CBPX_OP_MODAC), 32'h7, 32'h5);
    op(cmd(cbpx_pkg::CBPX_OP_MODAC), 32'h7, 32'h3);
    rdc(cbpx_pkg::OFF_RESULT, 32'h7, 32'h5, "modac_old");
    rdc(cbpx_pkg::OFF_ARITH, 32'h7, 32'h3, "modac_new");
    // mark needs the enable, forced mark does not
    op(cmd(cbpx_pkg::CBPX_OP_MARK));
    chk("mark_off", st[2], 0);
    op(cmd(cbpx_pkg::CBPX_OP_FMARK));
    chk("fmark", st[2], 1);
    rdc(cbpx_pkg::OFF_TRACE, 32'h800000, 32'h800000, "trace_evt");
    op(cmd(cbpx_pkg::CBPX_OP_MODTC), 32'h80, 32'h80);
    op(cmd(cbpx_pkg::CBPX_OP_MARK));
    chk("mark_on", st[2], 1);
    xfer(1, cbpx_pkg::OFF_TRACE, 32'h800000);
    rdc(cbpx_pkg::OFF_TRACE, 32'h800000, 32'h0, "trace_clr");
    // atomic add then atomic modify on one word
    x = $urandom;
    a = $urandom;
    b = $urandom;
    mem[32'h500] = x;
    xfer(1, cbpx_pkg::OFF_MEM, 32'h500);
    wq.delete();
    op(cmd(cbpx_pkg::CBPX_OP_ATADD), 0, b);
    op(cmd(cbpx_pkg::CBPX_OP_ATMOD), a, b);
    chk("atadd", wq[0], {32'h500, x + b});
    chk("atmod", wq[1], {32'h500, ((x + b) & ~a) | (b & a)});
    // halt, then leave it through the status register
    op(cmd(cbpx_pkg::CBPX_OP_HALT));
    chk("halt", {st[1], halt_out}, 2'b11);
    xfer(1, cbpx_pkg::OFF_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk("wake", halt_out, 0);
    complete_run();
  end
endmodule
